// ### pfsw_consts.vh
// Register offsets, field positions, reset values and timing counts of the flash self-write block
`ifndef PFSW_CONSTS_VH
`define PFSW_CONSTS_VH
`define PFSW_OFF_DATL        8'h00
`define PFSW_OFF_DATH        8'h04
`define PFSW_OFF_ADRL        8'h08
`define PFSW_OFF_ADRH        8'h0C
`define PFSW_OFF_CTRL        8'h10
`define PFSW_OFF_KEY         8'h14
`define PFSW_OFF_STAT        8'h18
`define PFSW_CTRL_RD         0
`define PFSW_CTRL_WR         1
`define PFSW_CTRL_WREN       2
`define PFSW_CTRL_ERR        3
`define PFSW_CTRL_ERASE      4
`define PFSW_CTRL_LATCH      5
`define PFSW_CTRL_AUX        6
`define PFSW_KEY_FIRST       8'h55
`define PFSW_KEY_SECOND      8'hAA
`define PFSW_LATCH_RESET     14'h03FF
`define PFSW_ROW_WORDS       32
`define PFSW_WRITE_TIME_NS   2000
`define PFSW_CLK_PERIOD_NS   8
`define PFSW_WRITE_CYCLES    ((`PFSW_WRITE_TIME_NS + `PFSW_CLK_PERIOD_NS - 1) / `PFSW_CLK_PERIOD_NS)
`define PFSW_UID_LO          16'h8000
`define PFSW_UID_HI          16'h8003
`define PFSW_DEV_LO          16'h8005
`define PFSW_DEV_HI          16'h8006
`define PFSW_CFG_LO          16'h8007
`define PFSW_CFG_HI          16'h800A
`define PFSW_EE_LO           16'hF000
`define PFSW_EE_HI           16'hF0FF
`endif

// ### pfsw_top.v
// Flash self-write sequencer with AHB-Lite register slave
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pfsw_consts.vh"
module pfsw_top #(
    parameter ROW_WORDS  = `PFSW_ROW_WORDS,
    parameter WP_LIMIT   = 15'h0800
) (
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        NRST,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire        HREADYOUT,
    output wire        HRESP,
    output reg  [31:0] HRDATA,
    // Nonvolatile array port
    output reg         NV_ERASE,
    output reg         NV_PROG,
    output reg         NV_READ,
    output reg  [15:0] NV_ADDR,
    output reg  [13:0] NV_WDATA,
    input  wire [13:0] NV_RDATA,
    output wire        NV_BUSY
);
    localparam ST_IDLE = 2'h0;
    localparam ST_BUSY = 2'h1;
    localparam ST_READ = 2'h2;
    localparam [15:0] WCYC = `PFSW_WRITE_CYCLES;
    localparam [15:0] ROWW = ROW_WORDS;

    // Reset release through two flops
    reg rst_s1_reg, rst_n;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    function aux_readable;
        input [15:0] a;
        begin
            aux_readable = (a >= `PFSW_UID_LO && a <= `PFSW_UID_HI) ||
                           (a >= `PFSW_DEV_LO && a <= `PFSW_CFG_HI) ||
                           (a >= `PFSW_EE_LO && a <= `PFSW_EE_HI);
        end
    endfunction

    function aux_writable;
        input [15:0] a;
        begin
            aux_writable = (a >= `PFSW_UID_LO && a <= `PFSW_UID_HI) ||
                           (a >= `PFSW_EE_LO && a <= `PFSW_EE_HI);
        end
    endfunction

    reg  [7:0]  datl_reg, dath_reg, adrl_reg, adrh_reg;
    reg         aux_reg, latch_reg, erase_reg, wren_reg, wr_reg, rd_reg, err_reg;
    reg  [1:0]  key_reg;
    reg  [1:0]  state_reg;
    reg  [15:0] cnt_reg;
    reg  [13:0] latch_mem [0:ROW_WORDS-1];
    reg         busy_was_reg;
    reg         row_prog_reg;

    // Address phase capture
    reg         ph_wr_reg, ph_rd_reg;
    reg  [7:0]  ph_addr_reg;
    wire        ph_take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign NV_BUSY   = (state_reg == ST_BUSY);

    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ph_wr_reg   <= 1'b0;
            ph_rd_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else begin
            ph_wr_reg   <= ph_take && HWRITE;
            ph_rd_reg   <= ph_take && !HWRITE;
            ph_addr_reg <= HADDR[7:0];
        end
    end

    wire        bus_wr   = ph_wr_reg;
    wire        key_wr   = bus_wr && ph_addr_reg == `PFSW_OFF_KEY;
    wire        ctrl_wr  = bus_wr && ph_addr_reg == `PFSW_OFF_CTRL;
    // Mode fields as they stand in the cycle of the strobe write, so a
    // strobe written together with its mode bits acts on those bits
    wire        cur_aux   = ctrl_wr ? HWDATA[`PFSW_CTRL_AUX] : aux_reg;
    wire        cur_latch = ctrl_wr ? HWDATA[`PFSW_CTRL_LATCH] : latch_reg;
    wire        cur_erase = ctrl_wr ? HWDATA[`PFSW_CTRL_ERASE] : erase_reg;
    wire        cur_wren  = ctrl_wr ? HWDATA[`PFSW_CTRL_WREN] : wren_reg;
    wire [15:0] tgt_addr  = {cur_aux, adrh_reg[6:0], adrl_reg};
    wire        tgt_ee    = cur_aux && tgt_addr >= `PFSW_EE_LO && tgt_addr <= `PFSW_EE_HI;

    function target_protected;
        input [15:0] a;
        begin
            if (a[15])
                target_protected = !aux_writable(a);
            else
                target_protected = a[14:0] < WP_LIMIT;
        end
    endfunction

    wire        tgt_prot   = target_protected(tgt_addr);
    wire        wr_req     = ctrl_wr && HWDATA[`PFSW_CTRL_WR] && !wr_reg && state_reg == ST_IDLE;
    wire        rd_req     = ctrl_wr && HWDATA[`PFSW_CTRL_RD] && state_reg == ST_IDLE;
    wire        unlocked   = key_reg == 2'h2 && cur_wren;
    wire        key_abort  = (key_reg != 2'h0) && bus_wr && !key_wr && !wr_req;
    wire [4:0]  lat_idx    = adrl_reg[4:0];
    wire [13:0] wr_word    = {dath_reg[5:0], datl_reg};
    wire        go_write   = wr_req && unlocked;
    wire        latch_load = go_write && cur_latch && !cur_erase;
    wire        prot_hit   = go_write && !latch_load && tgt_prot;
    wire        start_op   = go_write && !latch_load && !tgt_prot;
    wire [15:0] row_base   = {tgt_addr[15:5], 5'h00};
    // Program slots are the last row-length cycles of the write time
    wire [15:0] prog_idx   = ROWW - cnt_reg;
    wire        prog_slot  = row_prog_reg && cnt_reg != 16'h0000 && cnt_reg <= ROWW;
    // A row program ends by returning every latch to the erased pattern
    wire        row_done   = state_reg == ST_BUSY && cnt_reg == 16'h0001 && row_prog_reg;

    integer i;
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            datl_reg  <= 8'h00;
            dath_reg  <= 8'h00;
            adrl_reg  <= 8'h00;
            adrh_reg  <= 8'h00;
            aux_reg   <= 1'b0;
            latch_reg <= 1'b0;
            erase_reg <= 1'b0;
            wren_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            rd_reg    <= 1'b0;
            state_reg <= ST_IDLE;
            row_prog_reg <= 1'b0;
            cnt_reg   <= 16'h0000;
            NV_ERASE  <= 1'b0;
            NV_PROG   <= 1'b0;
            NV_READ   <= 1'b0;
            NV_ADDR   <= 16'h0000;
            NV_WDATA  <= 14'h0000;
        end else begin
            NV_ERASE <= 1'b0;
            NV_PROG  <= 1'b0;
            NV_READ  <= 1'b0;
            if (bus_wr) begin
                case (ph_addr_reg)
                    `PFSW_OFF_DATL: datl_reg <= HWDATA[7:0];
                    `PFSW_OFF_DATH: dath_reg <= {2'b00, HWDATA[5:0]};
                    `PFSW_OFF_ADRL: adrl_reg <= HWDATA[7:0];
                    `PFSW_OFF_ADRH: adrh_reg <= {1'b0, HWDATA[6:0]};
                    `PFSW_OFF_CTRL: begin
                        aux_reg   <= HWDATA[`PFSW_CTRL_AUX];
                        latch_reg <= HWDATA[`PFSW_CTRL_LATCH];
                        erase_reg <= HWDATA[`PFSW_CTRL_ERASE];
                        wren_reg  <= HWDATA[`PFSW_CTRL_WREN];
                    end
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE: begin
                    // Protected target: strobe stays clear, error set below
                    if (start_op) begin
                        wr_reg       <= 1'b1;
                        state_reg    <= ST_BUSY;
                        cnt_reg      <= WCYC;
                        row_prog_reg <= !cur_erase && !tgt_ee;
                        NV_ADDR      <= row_base;
                        if (cur_erase) begin
                            NV_ERASE <= 1'b1;
                        end else if (tgt_ee) begin
                            // Single byte, no row walk for EEPROM
                            NV_PROG  <= 1'b1;
                            NV_ADDR  <= tgt_addr;
                            NV_WDATA <= {6'h00, datl_reg};
                        end
                    end else if (rd_req) begin
                        rd_reg    <= 1'b1;
                        state_reg <= ST_READ;
                        NV_READ   <= 1'b1;
                        NV_ADDR   <= tgt_addr;
                    end
                end
                ST_BUSY: begin
                    // Row program walks the latches in the last cycles of the
                    // write time, one word per cycle, lowest index first
                    if (prog_slot) begin
                        NV_PROG  <= 1'b1;
                        NV_ADDR  <= {NV_ADDR[15:5], prog_idx[4:0]};
                        NV_WDATA <= latch_mem[prog_idx[4:0]];
                    end
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0001) begin
                        wr_reg    <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    rd_reg    <= 1'b0;
                    state_reg <= ST_IDLE;
                    if (aux_reg && !aux_readable(tgt_addr)) begin
                        datl_reg <= 8'h00;
                        dath_reg <= 8'h00;
                    end else begin
                        datl_reg <= NV_RDATA[7:0];
                        dath_reg <= {2'b00, NV_RDATA[13:8]};
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Unlock key tracking
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            key_reg <= 2'h0;
        end else if (key_wr && HWDATA[7:0] == `PFSW_KEY_FIRST) begin
            key_reg <= 2'h1;
        end else if (key_wr && HWDATA[7:0] == `PFSW_KEY_SECOND && key_reg == 2'h1) begin
            key_reg <= 2'h2;
        end else if (key_wr || key_abort || wr_req) begin
            key_reg <= 2'h0;
        end
    end

    // Write latches: one word per latch-only strobe, back to the erased
    // pattern once a row program has used them
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < ROW_WORDS; i = i + 1)
                latch_mem[i] <= `PFSW_LATCH_RESET;
        end else begin
            for (i = 0; i < ROW_WORDS; i = i + 1) begin
                if (latch_load && lat_idx == i[4:0])
                    latch_mem[i] <= wr_word;
                else if (row_done)
                    latch_mem[i] <= `PFSW_LATCH_RESET;
            end
        end
    end

    // Error flag lives outside device reset so a reset mid-write is recorded
    reg err_set;
    always @* begin
        err_set = 1'b0;
        if (prot_hit)
            err_set = 1'b1;
        if (key_abort || (wr_req && !unlocked))
            err_set = 1'b1;
        if (ctrl_wr && HWDATA[`PFSW_CTRL_ERR])
            err_set = 1'b1;
    end

    // No reset here: it must still hold the busy state when reset strikes
    always @(posedge CLK_SYS) begin
        if (rst_n)
            busy_was_reg <= NV_BUSY;
    end

    always @(posedge CLK_SYS) begin
        if (!rst_n) begin
            if (busy_was_reg)
                err_reg <= 1'b1;
        end else if (err_set)
            err_reg <= 1'b1;
        else if (ctrl_wr && !HWDATA[`PFSW_CTRL_ERR])
            err_reg <= 1'b0;
    end

    // Register view for the read data flop
    function [31:0] reg_view;
        input [7:0] a;
        begin
            case (a)
                `PFSW_OFF_DATL: reg_view = {24'h000000, datl_reg};
                `PFSW_OFF_DATH: reg_view = {24'h000000, dath_reg};
                `PFSW_OFF_ADRL: reg_view = {24'h000000, adrl_reg};
                `PFSW_OFF_ADRH: reg_view = {24'h000000, adrh_reg};
                `PFSW_OFF_CTRL: reg_view = {25'h0000000, aux_reg, latch_reg, erase_reg,
                                            err_reg === 1'b1, wren_reg, wr_reg, rd_reg};
                `PFSW_OFF_STAT: reg_view = {30'h00000000, state_reg};
                default:        reg_view = 32'h00000000;
            endcase
        end
    endfunction

    // Read data is captured with the address; a read whose address phase
    // overlaps a write's data phase returns the value before that write
    always @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n)
            HRDATA <= 32'h00000000;
        else if (ph_take && !HWRITE)
            HRDATA <= reg_view(HADDR[7:0]);
    end
endmodule // pfsw_top

// ### pfsw_checker_assertions.sv
// Port-level assertions for the flash self-write block
`timescale 1ns/1ps
module pfsw_checker #(
    parameter ROW_WORDS = 32,
    parameter WP_LIMIT  = 15'h0800
) (
    // Clock and reset
    input wire        CLK_SYS,
    input wire        NRST,
    // Register bus
    input wire        HSEL,
    input wire [1:0]  HTRANS,
    input wire        HWRITE,
    input wire [31:0] HADDR,
    input wire        HREADYOUT,
    input wire        HRESP,
    input wire [31:0] HRDATA,
    // Array port
    input wire        NV_ERASE,
    input wire        NV_PROG,
    input wire [15:0] NV_ADDR,
    input wire [13:0] NV_WDATA,
    input wire        NV_BUSY
);
    reg        rd_ph_reg;
    reg [7:0]  rd_off_reg;
    reg [15:0] busy_cnt_reg;
    // Aux region writable only at user IDs and EEPROM
    wire wp_hit = NV_ADDR[15] ? !(NV_ADDR <= 16'h8003 || NV_ADDR[15:8] == 8'hF0) : NV_ADDR[14:0] < WP_LIMIT;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rd_ph_reg    <= 1'b0;
            rd_off_reg   <= 8'h00;
            busy_cnt_reg <= 16'h0000;
        end else begin
            rd_ph_reg    <= HSEL && HTRANS[1] && !HWRITE && HREADYOUT;
            rd_off_reg   <= HADDR[7:0];
            busy_cnt_reg <= NV_BUSY ? busy_cnt_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    zero_wait_a: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not zero-wait OKAY");
    erase_align_a: assert property (NV_ERASE |-> NV_ADDR % ROW_WORDS == 0)
        else $error("erase address not row aligned");
    erase_pulse_a: assert property ($rose(NV_ERASE) |=> !NV_ERASE)
        else $error("erase command longer than one cycle");
    nv_perm_a: assert property ((NV_PROG || NV_ERASE) |-> !wp_hit)
        else $error("array changed at protected address");
    ee_low_a: assert property (NV_PROG && NV_ADDR[15:8] == 8'hF0 |-> NV_WDATA[13:8] == 6'h00)
        else $error("EEPROM write carries high data");
    datl_read_a: assert property (rd_ph_reg && rd_off_reg == 8'h00 |-> HRDATA[31:8] == 24'h0)
        else $error("low data read wider than eight bits");
    dath_read_a: assert property (rd_ph_reg && rd_off_reg == 8'h04 |-> HRDATA[31:6] == 26'h0)
        else $error("high data unimplemented bits not zero");
    busy_bound_a: assert property (busy_cnt_reg < 16'h4000)
        else $error("operation never finishes");
endmodule // pfsw_checker
bind pfsw_top pfsw_checker #(.ROW_WORDS(ROW_WORDS), .WP_LIMIT(WP_LIMIT)) u_chk (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HADDR(HADDR),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .NV_ERASE(NV_ERASE), .NV_PROG(NV_PROG),
    .NV_ADDR(NV_ADDR), .NV_WDATA(NV_WDATA), .NV_BUSY(NV_BUSY));

// ### program_flash_self_write_tb.sv
// Self-checking bench for the flash self-write block
`timescale 1ns/1ps
`include "pfsw_consts.vh"
module program_flash_self_write_tb;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] WRB = 32'h1 << `PFSW_CTRL_WR;
    localparam logic [31:0] STB = WRB | (32'h1 << `PFSW_CTRL_WREN);
    localparam logic [31:0] ERR = 32'h1 << `PFSW_CTRL_ERR;
    localparam logic [31:0] ERS = 32'h1 << `PFSW_CTRL_ERASE;
    localparam logic [31:0] LAT = 32'h1 << `PFSW_CTRL_LATCH;
    localparam logic [31:0] AUX = 32'h1 << `PFSW_CTRL_AUX;
    localparam logic [31:0] RDB = 32'h1 << `PFSW_CTRL_RD;
    reg          CLK_SYS = 1'b0;
    reg          NRST = 1'b0;
    reg          HSEL = 1'b0;
    reg  [31:0]  HADDR = 32'h0;
    reg  [1:0]   HTRANS = 2'h0;
    reg          HWRITE = 1'b0;
    reg  [31:0]  HWDATA = 32'h0;
    reg  [13:0]  NV_RDATA = 14'h0;
    wire         HREADYOUT, HRESP, NV_ERASE, NV_PROG, NV_BUSY;
    wire [31:0]  HRDATA;
    wire [15:0]  NV_ADDR;
    wire [13:0]  NV_WDATA;
    int          err_total = 0, comparisons = 0, nv_spur = 0, i, k;
    logic [63:0] rd_q[$], nv_q[$];
    logic [31:0] seed = 32'hB8E4DDCB, q, v;
    logic        rd_ph = 1'b0;
    logic        rdy = 1'b0;
    always #4 CLK_SYS = ~CLK_SYS;
    pfsw_top #(.ROW_WORDS(`PFSW_ROW_WORDS), .WP_LIMIT(15'h0800)) dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .NV_ERASE(NV_ERASE), .NV_PROG(NV_PROG), .NV_READ(),
        .NV_ADDR(NV_ADDR), .NV_WDATA(NV_WDATA), .NV_RDATA(NV_RDATA), .NV_BUSY(NV_BUSY));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic summarize();
        if (rd_q.size() + nv_q.size() > 0) begin
            err_total++;
            $display("[FAIL] %0t expected results never appeared", $time);
        end
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_rd(input logic [31:0] got, input logic [63:0] n);
        comparisons++;
        if ((got & n[63:32]) !== n[31:0]) begin
            err_total++;
            $display("[FAIL] %0t read %h expected %h", $time, got, n[31:0]);
        end
    endtask
    task automatic chk_nv(input logic [31:0] got, input logic [63:0] n);
        comparisons++;
        if ((got & n[63:32]) !== n[31:0]) begin
            err_total++;
            $display("[FAIL] %0t array op %h expected %h", $time, got, n[31:0]);
        end
    endtask
    // Watcher: read data phases and array commands
    always @(posedge CLK_SYS) begin
        NV_RDATA <= ~NV_RDATA;
        rd_ph <= HSEL && HTRANS[1] && !HWRITE;
    end
    // Outputs looked at mid-cycle, where they are settled
    always @(negedge CLK_SYS) begin
        if (rd_ph && rd_q.size() > 0) chk_rd(HRDATA, rd_q.pop_front());
        if ((NV_ERASE || NV_PROG) && nv_q.size() > 0) chk_nv({NV_ERASE, NV_PROG, NV_ADDR, NV_WDATA}, nv_q.pop_front());
        else if (NV_ERASE || NV_PROG) nv_spur++;
    end
    task automatic edge_rdy();
        for (int n = 0; n < 64; n++) begin
            @(negedge CLK_SYS);
            q = HRDATA;
            rdy = HREADYOUT;
            @(posedge CLK_SYS);
            if (rdy === 1'b1) return;
        end
        err_total++;
        summarize();
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        edge_rdy();
        HTRANS <= 2'h0;
        HWDATA <= d;
        edge_rdy();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_q.push_back({m, e & m});
        bus(1'b0, a, 32'h0);
    endtask
    // Bounded poll until the given control bits drop
    task automatic wait_bit(input logic [31:0] m);
        for (int n = 0; n < 20000; n++) begin
            bus(1'b0, `PFSW_OFF_CTRL, 32'h0);
            if ((q & m) === 32'h0) return;
        end
        err_total++;
        summarize();
    endtask
    task automatic strobe(input logic [31:0] c);
        bus(1'b1, `PFSW_OFF_KEY, {24'h0, `PFSW_KEY_FIRST});
        bus(1'b1, `PFSW_OFF_KEY, {24'h0, `PFSW_KEY_SECOND});
        bus(1'b1, `PFSW_OFF_CTRL, c | STB);
        wait_bit(WRB);
    endtask
    initial begin
        repeat (4) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        rd(`PFSW_OFF_DATL, ALL, 32'h0);
        rd(`PFSW_OFF_DATH, ALL, 32'h0);
        rd(`PFSW_OFF_ADRL, ALL, 32'h0);
        for (i = 0; i < 4; i++) begin
            v = rnd();
            bus(1'b1, `PFSW_OFF_DATL, v);
            bus(1'b1, `PFSW_OFF_DATH, v >> 8);
            bus(1'b1, `PFSW_OFF_ADRL, v >> 16);
            bus(1'b1, `PFSW_OFF_ADRH, v >> 24);
            rd(`PFSW_OFF_DATL, ALL, v & 32'hFF);
            rd(`PFSW_OFF_DATH, ALL, (v >> 8) & 32'h3F);
            rd(`PFSW_OFF_ADRL, ALL, (v >> 16) & 32'hFF);
            rd(`PFSW_OFF_ADRH, 32'h7F, v >> 24);
        end
        rd(8'h1C, ALL, 32'h0);
        bus(1'b1, `PFSW_OFF_ADRH, 32'h08);
        bus(1'b1, `PFSW_OFF_ADRL, 32'h03);
        bus(1'b1, `PFSW_OFF_CTRL, ERR);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        strobe(LAT | ERR);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 32; i++) nv_q.push_back({ALL, 2'b01, 16'h0800 + 16'(i), (k == 0 && i == 3) ? v[13:0] :
                `PFSW_LATCH_RESET});
            strobe(32'h0);
        end
        bus(1'b1, `PFSW_OFF_ADRL, 32'h25);
        for (i = 0; i < 2; i++) begin
            nv_q.push_back({32'hFFFFC000, 2'b10, 16'h0820, 14'h0});
            strobe(ERS | (i != 0 ? LAT : 32'h0));
        end
        bus(1'b1, `PFSW_OFF_KEY, {24'h0, `PFSW_KEY_FIRST});
        bus(1'b1, `PFSW_OFF_DATL, 32'h0);
        bus(1'b1, `PFSW_OFF_KEY, {24'h0, `PFSW_KEY_SECOND});
        bus(1'b1, `PFSW_OFF_CTRL, STB);
        wait_bit(WRB);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        bus(1'b1, `PFSW_OFF_ADRH, 32'h01);
        strobe(ERS);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        strobe(32'h0);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        bus(1'b1, `PFSW_OFF_ADRH, 32'h00);
        bus(1'b1, `PFSW_OFF_ADRL, 32'h07);
        strobe(AUX);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        bus(1'b1, `PFSW_OFF_DATL, 32'h5A);
        bus(1'b1, `PFSW_OFF_DATH, 32'h15);
        bus(1'b1, `PFSW_OFF_ADRL, 32'h04);
        bus(1'b1, `PFSW_OFF_CTRL, AUX | RDB);
        wait_bit(RDB);
        rd(`PFSW_OFF_DATL, ALL, 32'h0);
        rd(`PFSW_OFF_DATH, ALL, 32'h0);
        chk_nv(nv_spur, {ALL, 32'h0});
        // EEPROM pass only feeds the high-byte assertion
        bus(1'b1, `PFSW_OFF_ADRH, 32'h70);
        bus(1'b1, `PFSW_OFF_ADRL, 32'h00);
        bus(1'b1, `PFSW_OFF_DATH, 32'h3F);
        strobe(AUX | LAT);
        strobe(AUX);
        bus(1'b1, `PFSW_OFF_ADRH, 32'h08);
        bus(1'b1, `PFSW_OFF_KEY, {24'h0, `PFSW_KEY_FIRST});
        bus(1'b1, `PFSW_OFF_KEY, {24'h0, `PFSW_KEY_SECOND});
        bus(1'b1, `PFSW_OFF_CTRL, ERS | STB);
        repeat (20) @(posedge CLK_SYS);
        NRST <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        rd(`PFSW_OFF_CTRL, ERR, ERR);
        summarize();
    end
endmodule // program_flash_self_write_tb
